// file: design/adc_sar_control.sv
// Control logic of the 10-bit twelve-channel SAR converter
//
// Our own choice: the strobed register port.
module adc_sar_control (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sleep_mode,
    input wire logic rc_tick,
    input wire logic cmp_above,
    input wire logic [11:0] port_pins,
    output logic [3:0] mux_channel,
    output logic ref_external,
    output logic hold_connect,
    output logic sample_hold,
    output logic [9:0] dac_code,
    output logic [11:0] pin_analog,
    output logic converter_active,
    output logic conv_irq_flag
);

    // ==========================================================
    // Register fields

    logic [3:0] channel_select_q;
    logic go_q;
    logic converter_on_q;
    logic [1:0] conv_clock_select_q;
    logic result_justify_q;
    logic [2:0] pin_config_q;
    logic reference_select_q;
    logic [9:0] result_q;
    logic conv_irq_flag_q;

    // ==========================================================
    // Sequencing state

    adc_sar_pkg::ctl_state_t state_q;
    adc_sar_pkg::ctl_state_t state_d;
    logic [1:0] recover_cnt_q;
    logic hold_connect_q;
    logic converter_active_q;
    logic [11:0] pin_analog_q;
    logic [7:0] reg_rdata_q;
    logic [7:0] reg_rdata_d;

    // ==========================================================
    // Internal connections

    logic wr_control;
    logic wr_config;
    logic wr_irq;
    logic tad_tick;
    logic clock_enable;
    logic seq_start;
    logic seq_abort;
    logic seq_holding;
    logic seq_done;
    logic [9:0] seq_trial;
    logic [9:0] seq_result;
    logic [11:0] port_digital;

    // ==========================================================
    // Pin map decode, used for the pin outputs and the port read

    function automatic logic [11:0] pin_digital(input logic [2:0] code);
        pin_digital = adc_sar_pkg::PIN_DIGITAL[code];
    endfunction

    // ==========================================================
    // Write decode

    assign wr_control = reg_wr && (reg_addr == adc_sar_pkg::ADDR_CONTROL);
    assign wr_config = reg_wr && (reg_addr == adc_sar_pkg::ADDR_CONFIG);
    assign wr_irq = reg_wr && (reg_addr == adc_sar_pkg::ADDR_IRQ_STATUS);

    // ==========================================================
    // Control register: channel and on bit

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channel_select_q <= adc_sar_pkg::CONTROL_RESET[7:4];
            converter_on_q <= adc_sar_pkg::CONTROL_RESET[0];
        end else if (wr_control) begin
            channel_select_q <= reg_wdata[adc_sar_pkg::CTL_CHAN_HI:adc_sar_pkg::CTL_CHAN_LO];
            converter_on_q <= reg_wdata[adc_sar_pkg::CTL_ON];
        end
    end

    // ==========================================================
    // Start/done bit

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            go_q <= adc_sar_pkg::CONTROL_RESET[2];
        end else if (!converter_on_q) begin
            go_q <= 1'b0;
        end else if (wr_control) begin
            // Taken only when already on, never in the turn-on write
            go_q <= reg_wdata[adc_sar_pkg::CTL_GO];
        end else if (seq_done) begin
            go_q <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration register

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conv_clock_select_q <= adc_sar_pkg::CONFIG_RESET[7:6];
            result_justify_q <= adc_sar_pkg::CONFIG_RESET[5];
            pin_config_q <= adc_sar_pkg::CONFIG_RESET[3:1];
            reference_select_q <= adc_sar_pkg::CONFIG_RESET[0];
        end else if (wr_config) begin
            conv_clock_select_q <= reg_wdata[adc_sar_pkg::CFG_CLK_HI:adc_sar_pkg::CFG_CLK_LO];
            result_justify_q <= reg_wdata[adc_sar_pkg::CFG_JUSTIFY];
            pin_config_q <= reg_wdata[adc_sar_pkg::CFG_PIN_HI:adc_sar_pkg::CFG_PIN_LO];
            reference_select_q <= reg_wdata[adc_sar_pkg::CFG_REF];
        end
    end

    // ==========================================================
    // Result pair, loaded only by a completed conversion

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_q <= 10'h000;
        end else if (seq_done) begin
            result_q <= seq_result;
        end
    end

    // ==========================================================
    // Completion flag, a set beats a clear in the same cycle

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conv_irq_flag_q <= 1'b0;
        end else if (seq_done) begin
            conv_irq_flag_q <= 1'b1;
        end else if (wr_irq) begin
            conv_irq_flag_q <= reg_wdata[adc_sar_pkg::IRQ_FLAG_BIT];
        end
    end

    // ==========================================================
    // Conversion sequencing

    assign clock_enable = (state_q != adc_sar_pkg::ST_OFF);
    assign seq_start = (state_q == adc_sar_pkg::ST_ACQUIRE) && converter_on_q && go_q;
    assign seq_abort = (state_q == adc_sar_pkg::ST_CONVERT) && (!go_q || !converter_on_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            adc_sar_pkg::ST_OFF: begin
                if (converter_on_q) begin
                    state_d = adc_sar_pkg::ST_ACQUIRE;
                end
            end

            adc_sar_pkg::ST_ACQUIRE: begin
                if (!converter_on_q) begin
                    state_d = adc_sar_pkg::ST_OFF;
                end else if (go_q) begin
                    state_d = adc_sar_pkg::ST_CONVERT;
                end
            end

            adc_sar_pkg::ST_CONVERT: begin
                if (!converter_on_q) begin
                    state_d = adc_sar_pkg::ST_OFF;
                end else if (seq_done || !go_q) begin
                    state_d = adc_sar_pkg::ST_RECOVER;
                end
            end

            adc_sar_pkg::ST_RECOVER: begin
                if (!converter_on_q) begin
                    state_d = adc_sar_pkg::ST_OFF;
                end else if (tad_tick && (recover_cnt_q == adc_sar_pkg::RECOVER_TADS - 2'h1)) begin
                    state_d = adc_sar_pkg::ST_ACQUIRE;
                end
            end
            default: state_d = adc_sar_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= adc_sar_pkg::ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Wait of two bit periods after each conversion or start-bit abort; turning off goes straight to off

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            recover_cnt_q <= 2'h0;
        end else if (state_q != adc_sar_pkg::ST_RECOVER) begin
            recover_cnt_q <= 2'h0;
        end else if (tad_tick) begin
            recover_cnt_q <= recover_cnt_q + 2'h1;
        end
    end

    // ==========================================================
    // Analog side outputs

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_connect_q <= 1'b0;
            converter_active_q <= 1'b0;
        end else begin
            // Hold capacitor tracks the channel only while acquiring
            hold_connect_q <= (state_d == adc_sar_pkg::ST_ACQUIRE);
            converter_active_q <= (state_d != adc_sar_pkg::ST_OFF);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_analog_q <= 12'hFFF;
        end else begin
            pin_analog_q <= ~pin_digital(pin_config_q);
        end
    end

    // ==========================================================
    // Tick generator and bit sequencer

    conv_clock_gen u_clock (
        .clk(clk),
        .resetn(resetn),
        .enable(clock_enable),
        .clock_select(conv_clock_select_q),
        .sleep_mode(sleep_mode),
        .rc_tick(rc_tick),
        .tad_tick(tad_tick)
    );

    sar_sequencer u_sequencer (
        .clk(clk),
        .resetn(resetn),
        .start(seq_start),
        .abort(seq_abort),
        .tad_tick(tad_tick),
        .cmp_above(cmp_above),
        .holding(seq_holding),
        .trial_code(seq_trial),
        .done(seq_done),
        .result(seq_result)
    );

    // ==========================================================
    // Read path, data valid in the cycle after the strobe only

    assign port_digital = port_pins & pin_digital(pin_config_q);

    always_comb begin
        reg_rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                adc_sar_pkg::ADDR_CONTROL: begin
                    reg_rdata_d = {channel_select_q, 1'b0, go_q, 1'b0,
                        converter_on_q};
                end
                adc_sar_pkg::ADDR_CONFIG: begin
                    reg_rdata_d = {conv_clock_select_q, result_justify_q, 1'b0,
                        pin_config_q, reference_select_q};
                end
                adc_sar_pkg::ADDR_RESULT_HIGH: begin
                    if (result_justify_q) begin
                        reg_rdata_d = {6'h00, result_q[9:8]};
                    end else begin
                        reg_rdata_d = result_q[9:2];
                    end
                end
                adc_sar_pkg::ADDR_RESULT_LOW: begin
                    if (result_justify_q) begin
                        reg_rdata_d = result_q[7:0];
                    end else begin
                        reg_rdata_d = {result_q[1:0], 6'h00};
                    end
                end
                adc_sar_pkg::ADDR_IRQ_STATUS: begin
                    reg_rdata_d = {7'h00, conv_irq_flag_q};
                end
                adc_sar_pkg::ADDR_PORT_LOW: begin
                    reg_rdata_d = port_digital[7:0];
                end
                adc_sar_pkg::ADDR_PORT_HIGH: begin
                    reg_rdata_d = {4'h0, port_digital[11:8]};
                end
                default: reg_rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // ==========================================================
    // Output flops

    logic sample_hold_q;
    logic [9:0] dac_code_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_hold_q <= 1'b0;
            dac_code_q <= 10'h000;
        end else begin
            sample_hold_q <= seq_holding && !seq_abort;
            dac_code_q <= seq_trial;
        end
    end

    assign reg_rdata = reg_rdata_q;

    assign mux_channel = channel_select_q;
    assign ref_external = reference_select_q;
    assign hold_connect = hold_connect_q;
    assign sample_hold = sample_hold_q;
    assign dac_code = dac_code_q;
    assign pin_analog = pin_analog_q;
    assign converter_active = converter_active_q;
    assign conv_irq_flag = conv_irq_flag_q;
endmodule

// file: shared/adc_sar_pkg.sv
// Constants, register map and types of the SAR converter control block
//
// Overview of operation
// - Upper nibble of control picks analog channel 0 to 11 by value.
// - Each conversion yields a 10-bit result by successive approximation.
// - Config bit 0 set selects external references, clear selects supply rails.
// - Conversion may continue in sleep only with internal RC clock.
// - Config bits 7:6 pick clock: divide by 8, 32, 64, or RC.
// - Justify bit 5 set gives right justified result, clear gives left.
// - Three-bit pin field sets analog or digital role per mapping table.
// - Completion loads result, clears start bit and sets interrupt flag together.
// - Two bit periods pass after a conversion before acquisition resumes.
// - Control bits 3 and 1 and config bit 4 read as zero.
// - All implemented control and config bits reset to zero.
// - Clearing start bit aborts, keeps result, reacquires after two bit periods.
// - A full conversion takes at least eleven bit periods.
// - Port read returns zero for pins configured as analog.
package adc_sar_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h14;
    localparam logic [7:0] ADDR_CONFIG = 8'h15;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h16;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h17;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_PORT_LOW = 8'h19;
    localparam logic [7:0] ADDR_PORT_HIGH = 8'h1A;
    // ==========================================================
    // Field positions and reset values
    localparam int CTL_CHAN_HI = 7;
    localparam int CTL_CHAN_LO = 4;
    localparam int CTL_GO = 2;
    localparam int CTL_ON = 0;
    localparam int CFG_CLK_HI = 7;
    localparam int CFG_CLK_LO = 6;
    localparam int CFG_JUSTIFY = 5;
    localparam int CFG_PIN_HI = 3;
    localparam int CFG_PIN_LO = 1;
    localparam int CFG_REF = 0;
    localparam int IRQ_FLAG_BIT = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // ==========================================================
    // Clock selection and timing counts
    localparam logic [1:0] CLK_DIV8 = 2'h0;
    localparam logic [1:0] CLK_DIV32 = 2'h1;
    localparam logic [1:0] CLK_DIV64 = 2'h2;
    localparam logic [1:0] CLK_RC = 2'h3;
    localparam logic [5:0] DIV8_LAST = 6'h07;
    localparam logic [5:0] DIV32_LAST = 6'h1F;
    localparam logic [5:0] DIV64_LAST = 6'h3F;
    localparam logic [1:0] RECOVER_TADS = 2'h2;
    localparam logic [9:0] SAR_MSB = 10'h200;
    // ==========================================================
    // Digital pins per pin configuration code
    localparam logic [11:0] PIN_DIGITAL [8] = '{12'h000, 12'h080, 12'h0C0, 12'h0E0,
        12'h0F0, 12'h8F8, 12'hCFC, 12'hFFF};
    typedef enum {ST_OFF, ST_ACQUIRE, ST_CONVERT, ST_RECOVER} ctl_state_t;
    typedef enum {SEQ_IDLE, SEQ_SAMPLE, SEQ_BITS, SEQ_FINISH} seq_state_t;
endpackage

// file: design/conv_clock_gen.sv
// Conversion bit period tick generator
module conv_clock_gen (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [1:0] clock_select,
    input wire logic sleep_mode,
    input wire logic rc_tick,
    output logic tad_tick
);
    logic [5:0] div_cnt_q;
    logic tad_tick_q;

    // ==========================================================
    // Divider terminal count
    function automatic logic [5:0] div_last(input logic [1:0] sel);
        case (sel)
            adc_sar_pkg::CLK_DIV32: div_last = adc_sar_pkg::DIV32_LAST;
            adc_sar_pkg::CLK_DIV64: div_last = adc_sar_pkg::DIV64_LAST;
            default: div_last = adc_sar_pkg::DIV8_LAST;
        endcase
    endfunction

    // ==========================================================
    // Tick generation
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q <= 6'h00;
            tad_tick_q <= 1'b0;
        end else if (!enable) begin
            div_cnt_q <= 6'h00;
            tad_tick_q <= 1'b0;
        end else if (clock_select == adc_sar_pkg::CLK_RC) begin
            div_cnt_q <= 6'h00;
            tad_tick_q <= rc_tick;
        end else if (sleep_mode) begin
            tad_tick_q <= 1'b0;
        end else if (div_cnt_q >= div_last(clock_select)) begin
            div_cnt_q <= 6'h00;
            tad_tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 6'h01;
            tad_tick_q <= 1'b0;
        end
    end

    assign tad_tick = tad_tick_q;
endmodule

// file: design/sar_sequencer.sv
// Successive approximation bit sequencer
module sar_sequencer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic abort,
    input wire logic tad_tick,
    input wire logic cmp_above,
    output logic holding,
    output logic [9:0] trial_code,
    output logic done,
    output logic [9:0] result
);
    adc_sar_pkg::seq_state_t state_q;
    logic [9:0] bit_q;
    logic [9:0] code_q;
    logic done_q;

    // ==========================================================
    // Sample, ten bit decisions, finish: twelve periods in all
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= adc_sar_pkg::SEQ_IDLE;
            bit_q <= 10'h000;
            code_q <= 10'h000;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (abort) begin
                state_q <= adc_sar_pkg::SEQ_IDLE;
            end else begin
                case (state_q)
                    adc_sar_pkg::SEQ_IDLE: begin
                        if (start) begin
                            state_q <= adc_sar_pkg::SEQ_SAMPLE;
                        end
                    end
                    adc_sar_pkg::SEQ_SAMPLE: begin
                        if (tad_tick) begin
                            state_q <= adc_sar_pkg::SEQ_BITS;
                            bit_q <= adc_sar_pkg::SAR_MSB;
                            code_q <= adc_sar_pkg::SAR_MSB;
                        end
                    end
                    adc_sar_pkg::SEQ_BITS: begin
                        if (tad_tick) begin
                            // Keep or drop the trial bit, try the next one
                            code_q <= (cmp_above ? code_q : (code_q & ~bit_q))
                                | (bit_q >> 1);
                            bit_q <= bit_q >> 1;
                            if (bit_q[0]) begin
                                state_q <= adc_sar_pkg::SEQ_FINISH;
                            end
                        end
                    end
                    adc_sar_pkg::SEQ_FINISH: begin
                        if (tad_tick) begin
                            state_q <= adc_sar_pkg::SEQ_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                    default: state_q <= adc_sar_pkg::SEQ_IDLE;
                endcase
            end
        end
    end

    assign holding = (state_q != adc_sar_pkg::SEQ_IDLE);
    assign trial_code = code_q;
    assign done = done_q;
    assign result = code_q;
endmodule

// file: verif/sar_analog_model.sv
// Analog front end model: hold capacitor and comparator
module sar_analog_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hold_connect,
    input wire logic [9:0] level,
    input wire logic [9:0] dac_code,
    output logic cmp_above
);
    timeunit 1ns / 1ps;
    logic [9:0] held_q;
    // ====
    // Capacitor tracks the channel only while connected
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            held_q <= 10'h000;
        end else if (hold_connect) begin
            held_q <= level;
        end
    end
    assign cmp_above = held_q >= dac_code;
endmodule

// file: verif/adc_sar_control_chk.sv
// Concurrent checks on the ports of the converter control block
module adc_sar_control_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sleep_mode,
    input wire logic [3:0] mux_channel,
    input wire logic ref_external,
    input wire logic hold_connect,
    input wire logic sample_hold,
    input wire logic [9:0] dac_code,
    input wire logic [11:0] pin_analog,
    input wire logic converter_active,
    input wire logic conv_irq_flag
);
    timeunit 1ns / 1ps;
    logic just_q;
    logic wcfg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    assign wcfg = reg_wr && reg_addr == 8'h15;
    // ====
    // Shadow of the justify bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            just_q <= 1'b0;
        end else if (wcfg) begin
            just_q <= reg_wdata[5];
        end
    end
    // ====
    // Properties
    AST_CHAN: assert property (reg_wr && reg_addr == 8'h14 |=>
        mux_channel == $past(reg_wdata[7:4])) else $error("channel not applied");
    AST_REF: assert property (wcfg |=> ref_external == $past(reg_wdata[0]))
        else $error("reference not applied");
    AST_PIN: assert property (wcfg |=> ##1
        pin_analog == ~adc_sar_pkg::PIN_DIGITAL[$past(reg_wdata[3:1], 2)]) else $error("pin map");
    AST_CTL_ZERO: assert property (reg_rd && reg_addr == 8'h14 |=>
        (reg_rdata & 8'h0A) == 8'h00) else $error("control spare bits");
    AST_CFG_ZERO: assert property (reg_rd && reg_addr == 8'h15 |=>
        (reg_rdata & 8'h10) == 8'h00) else $error("config spare bit");
    AST_JUST_R: assert property (reg_rd && reg_addr == 8'h16 && just_q |=>
        reg_rdata[7:2] == 6'h00) else $error("right justify high bits");
    AST_JUST_L: assert property (reg_rd && reg_addr == 8'h17 && !just_q |=>
        reg_rdata[5:0] == 6'h00) else $error("left justify low bits");
    AST_OFF: assert property (!converter_active && !$past(converter_active) |->
        !sample_hold && !hold_connect) else $error("active while off");
    AST_RECOVER: assert property ($fell(sample_hold) |-> !hold_connect [*4])
        else $error("reacquired too soon");
    AST_IRQ: assert property ($rose(conv_irq_flag) |-> $past(sample_hold))
        else $error("flag without conversion");
    AST_MSB: assert property ($rose(sample_hold) |-> ##[1:600]
        (dac_code == 10'h200 && sample_hold)) else $error("first trial not msb");
    cover property ($rose(conv_irq_flag));
    cover property (sleep_mode && sample_hold);
    cover property ($fell(sample_hold) && !conv_irq_flag);
endmodule

bind adc_sar_control adc_sar_control_chk chk_u (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_mode(sleep_mode), .mux_channel(mux_channel),
    .ref_external(ref_external), .hold_connect(hold_connect), .sample_hold(sample_hold),
    .dac_code(dac_code), .pin_analog(pin_analog), .converter_active(converter_active),
    .conv_irq_flag(conv_irq_flag));

// file: verif/tb_top.sv
// Self-checking bench of the converter control block
module tb_top;
    timeunit 1ns / 1ps;
    logic clk, resetn, reg_wr, reg_rd, sleep_mode, rc_tick, cmp_above;
    logic ref_external, hold_connect, sample_hold, converter_active, conv_irq_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, hi_e, lo_e;
    logic [11:0] port_pins, pin_analog;
    logic [3:0] mux_channel, ch;
    logic [9:0] dac_code, lvl;
    logic [9:0] lvl_tbl [16];
    logic [2:0] rc_cnt = 3'h0;
    int errors = 0, num_checks = 0, cyc = 0, t0;
    adc_sar_control dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_mode(sleep_mode), .rc_tick(rc_tick), .cmp_above(cmp_above),
        .port_pins(port_pins), .mux_channel(mux_channel), .ref_external(ref_external),
        .hold_connect(hold_connect), .sample_hold(sample_hold), .dac_code(dac_code),
        .pin_analog(pin_analog), .converter_active(converter_active),
        .conv_irq_flag(conv_irq_flag));
    sar_analog_model model_u (.clk(clk), .resetn(resetn), .hold_connect(hold_connect),
        .level(lvl), .dac_code(dac_code), .cmp_above(cmp_above));
    assign lvl = lvl_tbl[mux_channel];
    // ====
    // Clock, RC ticks and timeout
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
        rc_tick <= rc_cnt == 3'h4;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            end_of_test();
        end
    end
    // ====
    // Tasks
    task automatic chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic conv(input logic [1:0] cs, input logic slp, input logic j);
        logic [7:0] d;
        logic [9:0] x;
        int conv_bit_period;
        ch = 4'($urandom % 12);
        x = lvl_tbl[ch];
        conv_bit_period = (cs == 2'h0) ? 8 : (cs == 2'h1) ? 32 : (cs == 2'h2) ? 64 : 5;
        hi_e = j ? {6'h00, x[9:8]} : x[9:2];
        lo_e = j ? x[7:0] : {x[1:0], 6'h00};
        wr_reg(8'h15, {cs, j, 5'h00});
        wr_reg(8'h18, 8'h00);
        wr_reg(8'h14, {ch, 4'h1});
        sleep_mode <= slp;
        repeat (200) @(posedge clk);
        chk("channel", mux_channel, ch);
        wr_reg(8'h14, {ch, 4'h5});
        t0 = cyc;
        if (slp && cs != 2'h3) begin
            repeat (250) @(posedge clk);
            rd_reg(8'h14, d);
            chk("frozen", d[2], 1'b1);
            @(posedge clk);
            sleep_mode <= 1'b0;
        end
        d = 8'h04;
        for (int i = 0; i < 600 && d[2] === 1'b1; i++)
            rd_reg(8'h14, d);
        chk("done", d[2], 1'b0);
        chk("duration", (cyc - t0) >= 11 * conv_bit_period, 1'b1);
        chk("flag", conv_irq_flag, 1'b1);
        rd_reg(8'h16, d);
        chk("result_high", d, hi_e);
        rd_reg(8'h17, d);
        chk("result_low", d, lo_e);
    endtask
    // ====
    // Main sequence
    initial begin
        logic [7:0] r, d;
        {reg_wr, reg_rd, sleep_mode, resetn} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        port_pins = 12'h000;
        void'($urandom(19));
        for (int i = 0; i < 16; i++)
            lvl_tbl[i] = 10'($urandom);
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(8'h14, r);
        chk("control", r, 8'h00);
        rd_reg(8'h15, r);
        chk("config", r, 8'h00);
        rd_reg(8'h30, r);
        chk("unmapped", r, 8'h00);
        chk("analog", pin_analog, 12'hFFF);
        wr_reg(8'h14, 8'hBA);
        rd_reg(8'h14, r);
        chk("control", r, 8'hB0);
        for (int k = 0; k < 8; k++) begin
            d = 8'($urandom) & 8'hF1 | 8'(k << 1);
            wr_reg(8'h15, d);
            port_pins <= 12'($urandom);
            rd_reg(8'h15, r);
            chk("config", r, d & 8'hEF);
            chk("pins", pin_analog, ~adc_sar_pkg::PIN_DIGITAL[k]);
            chk("ref", ref_external, d[0]);
            rd_reg(8'h19, r);
            chk("port_lo", r, port_pins[7:0] & adc_sar_pkg::PIN_DIGITAL[k][7:0]);
            rd_reg(8'h1A, r);
            chk("port_hi", r, port_pins[11:8] & adc_sar_pkg::PIN_DIGITAL[k][11:8]);
        end
        for (int i = 0; i < 8; i++)
            conv(2'(i), i > 3, ^3'(i));
        wr_reg(8'h18, 8'h00);
        for (int i = 0; i < 16; i++)
            lvl_tbl[i] = ~lvl_tbl[i];
        wr_reg(8'h14, {ch, 4'h5});
        repeat (25) @(posedge clk);
        wr_reg(8'h14, {ch, 4'h1});
        repeat (100) @(posedge clk);
        rd_reg(8'h16, r);
        chk("abort_high", r, hi_e);
        rd_reg(8'h17, r);
        chk("abort_low", r, lo_e);
        rd_reg(8'h14, r);
        chk("abort_go", r, {ch, 4'h1});
        chk("abort_flag", conv_irq_flag, 1'b0);
        chk("reacquire", hold_connect, 1'b1);
        wr_reg(8'h14, 8'h00);
        repeat (2) @(negedge clk);
        chk("active", converter_active, 1'b0);
        wr_reg(8'h14, 8'h05);
        rd_reg(8'h14, r);
        chk("on_and_go", r, 8'h01);
        end_of_test();
    end
endmodule
